// *** hdl/qdc_consts.svh ***
// constants of the quad dac serial command port
`ifndef QDC_CONSTS_SVH
`define QDC_CONSTS_SVH

// frame layout
`define QDC_FRAME_BITS     24
`define QDC_CMD_HI         21
`define QDC_CMD_LO         19
`define QDC_ADDR_HI        18
`define QDC_ADDR_LO        16
`define QDC_DATA_HI        15
`define QDC_PD_MODE_HI     5
`define QDC_PD_MODE_LO     4
`define QDC_RESET_SCOPE    0

// command codes
`define QDC_CMD_WR_IN      3'h0
`define QDC_CMD_UPD        3'h1
`define QDC_CMD_WR_UPD_ALL 3'h2
`define QDC_CMD_WR_UPD     3'h3
`define QDC_CMD_POWER      3'h4
`define QDC_CMD_RESET      3'h5
`define QDC_CMD_LOAD_CTRL  3'h6
`define QDC_CMD_RSVD       3'h7

// channel address codes
`define QDC_ADDR_ALL       3'h7

// link timing, least frame-select high time
`define QDC_SYNC_HIGH_NS   15
`define QDC_CLK_NS         20
`define QDC_SYNC_HIGH_CYC  ((`QDC_SYNC_HIGH_NS + `QDC_CLK_NS - 1) / `QDC_CLK_NS)

// register word offsets (byte addresses)
`define QDC_REG_CTRL       8'h00
`define QDC_REG_STATUS     8'h04
`define QDC_REG_FRAMES     8'h08
`define QDC_REG_CHAN_BASE  8'h10

// field positions and reset values
`define QDC_CTRL_EN_BIT    0
`define QDC_CTRL_RESET     1'h1
`define QDC_ST_LOAD_LO     8
`define QDC_ST_BUSY_BIT    12

`endif

// *** hdl/qdc_pkg.sv ***
// types of the quad dac serial command port
package qdc_pkg;

  // frame receiver states, one-hot
  typedef enum logic [2:0] {
    QDC_IDLE  = 3'b001,
    QDC_SHIFT = 3'b010,
    QDC_DONE  = 3'b100
  } qdc_state_t;

  // output stage modes of a channel
  typedef enum logic [1:0] {
    QDC_PD_NORMAL = 2'h0,
    QDC_PD_1K     = 2'h1,
    QDC_PD_100K   = 2'h2,
    QDC_PD_TRI    = 2'h3
  } qdc_pd_mode_t;

endpackage : qdc_pkg

// *** hdl/qdc_top.sv ***
// serial command port of a quad dac with a wishbone status port
// How it works
// - frame-select low starts frame; shift on falls
// - 24th falling edge executes decoded command
// - msb first: 2 ignored, command, address, data
// - code left-aligned; 12-bit drops four low bits
// - commands 000-011: write, update, broadcast, both
// - 100 power, 101 reset, 110 load-control, 111 reserved
// - address 0-3 single channel, 7 all four
// - early frame-select rise discards the frame
// - channels power up at zero code
// - reset scope 0 clears channels and shift register
// - reset scope 1 also clears load and power state
// - power mode from frame bits 5 and 4
// - bits 3..0 pick channels taking that mode
// - channel codes are unsigned straight binary
// - mode 00 normal, 01 1k, 10 100k, 11 tristate
// - power-down leaves non-transparent channel codes unchanged
// - load-control bits copy input on every frame but reset and reserved
`timescale 1ns/1ns
`include "qdc_consts.svh"
`default_nettype none

module qdc_top
  import qdc_pkg::*;
#(
  parameter int CODE_W = 16
)(
  // clock and reset
  input  wire logic                  REF_CLK_I,
  input  wire logic                  SYS_RST_I,
  // serial link pins
  input  wire logic                  FRAME_SEL_N_I,
  input  wire logic                  SER_CLK_I,
  input  wire logic                  SER_DATA_I,
  // wishbone slave
  input  wire logic                  WB_CYC_I,
  input  wire logic                  WB_STB_I,
  input  wire logic                  WB_WE_I,
  input  wire logic [7:0]            WB_ADR_I,
  input  wire logic [3:0]            WB_SEL_I,
  input  wire logic [31:0]           WB_DAT_I,
  output logic      [31:0]           WB_DAT_O,
  output logic                       WB_ACK_O,
  // channel state to the converter
  output logic      [4*CODE_W-1:0]   CHAN_CODE_O,
  output logic      [7:0]            PD_MODE_O,
  output logic      [3:0]            LOAD_CTRL_O,
  output logic                       FRAME_DONE_O
);

  localparam logic [4:0] LAST_BIT = 5'(`QDC_FRAME_BITS - 1);

  // synchronisers and edge history
  logic [2:0]                 sync_n_q;
  logic [2:0]                 sclk_q;
  logic [1:0]                 din_q;
  logic                       sync_fall;
  logic                       sclk_fall;
  logic                       sync_high;
  // frame receiver
  qdc_state_t                 state_q;
  logic [4:0]                 cnt_q;
  logic [`QDC_FRAME_BITS-1:0] shift_q;
  logic [`QDC_FRAME_BITS-1:0] word;
  logic                       exec_go;
  logic [2:0]                 cmd;
  logic [2:0]                 addr;
  logic [CODE_W-1:0]          code;
  logic [3:0]                 mask;
  // channel state
  logic [3:0][CODE_W-1:0]     inreg_q;
  logic [3:0][CODE_W-1:0]     inreg_d;
  logic [3:0][CODE_W-1:0]     chreg_q;
  logic [3:0][CODE_W-1:0]     chreg_d;
  logic [3:0][1:0]            pd_q;
  logic [3:0][1:0]            pd_d;
  logic [3:0]                 ld_q;
  logic [3:0]                 ld_d;
  // registers
  logic                       en_q;
  logic [15:0]                frames_q;
  logic                       ack_q;
  logic [31:0]                rdat_q;
  logic                       done_q;

  // two flip-flops on every pin, third stage only for edges
  always_ff @(posedge REF_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      sync_n_q <= 3'h7;
      sclk_q   <= 3'h7;
      din_q    <= 2'h0;
    end
    else
    begin
      sync_n_q <= {sync_n_q[1:0], FRAME_SEL_N_I};
      sclk_q   <= {sclk_q[1:0], SER_CLK_I};
      din_q    <= {din_q[0], SER_DATA_I};
    end
  end

  // edge detection on synchronised levels
  assign sync_high = sync_n_q[1];
  assign sync_fall = sync_n_q[2] & ~sync_n_q[1];
  assign sclk_fall = sclk_q[2] & ~sclk_q[1];

  // assembled word on the last edge and its fields
  assign word    = {shift_q[`QDC_FRAME_BITS-2:0], din_q[1]};
  assign exec_go = (state_q == QDC_SHIFT) && !sync_high && sclk_fall
                   && (cnt_q == LAST_BIT);
  assign cmd     = word[`QDC_CMD_HI:`QDC_CMD_LO];
  assign addr    = word[`QDC_ADDR_HI:`QDC_ADDR_LO];
  assign code    = word[`QDC_DATA_HI -: CODE_W];

  // channel address decode
  always_comb
  begin
    mask = 4'h0;
    if (addr == `QDC_ADDR_ALL)
      mask = 4'hF;
    else if (addr[2] == 1'b0)
      mask[addr[1:0]] = 1'b1;
  end

  // frame receiver
  always_ff @(posedge REF_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      state_q <= QDC_IDLE;
      cnt_q   <= 5'h0;
      shift_q <= '0;
    end
    else
    begin
      unique case (state_q)
        QDC_IDLE:
        begin
          if (sync_fall && en_q)
          begin
            state_q <= QDC_SHIFT;
            cnt_q   <= 5'h0;
            shift_q <= '0;
          end
        end
        QDC_SHIFT:
        begin
          if (sync_high)
          begin
            state_q <= QDC_IDLE;
            shift_q <= '0;
          end
          else if (sclk_fall)
          begin
            shift_q <= word;
            cnt_q   <= cnt_q + 5'h1;
            if (exec_go)
              state_q <= QDC_DONE;
          end
        end
        QDC_DONE:
        begin
          if (sync_high)
            state_q <= QDC_IDLE;
          if (exec_go == 1'b0 && cmd == `QDC_CMD_RESET)
            shift_q <= shift_q;
        end
      endcase
      if (exec_go && cmd == `QDC_CMD_RESET)
        shift_q <= '0;
    end
  end

  // command execution, next channel state
  always_comb
  begin
    inreg_d = inreg_q;
    chreg_d = chreg_q;
    pd_d    = pd_q;
    ld_d    = ld_q;
    if (exec_go)
    begin
      unique case (cmd)
        `QDC_CMD_WR_IN:
          for (int i = 0; i < 4; i++)
            if (mask[i]) inreg_d[i] = code;
        `QDC_CMD_UPD:
          for (int i = 0; i < 4; i++)
            if (mask[i]) chreg_d[i] = inreg_q[i];
        `QDC_CMD_WR_UPD_ALL:
        begin
          for (int i = 0; i < 4; i++)
            if (mask[i]) inreg_d[i] = code;
          chreg_d = inreg_d;
        end
        `QDC_CMD_WR_UPD:
          for (int i = 0; i < 4; i++)
            if (mask[i])
            begin
              inreg_d[i] = code;
              chreg_d[i] = code;
            end
        `QDC_CMD_POWER:
          for (int i = 0; i < 4; i++)
            if (word[i])
              pd_d[i] = word[`QDC_PD_MODE_HI:`QDC_PD_MODE_LO];
        `QDC_CMD_RESET:
        begin
          chreg_d = '0;
          if (word[`QDC_RESET_SCOPE])
          begin
            inreg_d = '0;
            pd_d    = '0;
            ld_d    = 4'h0;
          end
        end
        `QDC_CMD_LOAD_CTRL:
          ld_d = word[3:0];
        `QDC_CMD_RSVD:
          ;
      endcase
      // transparent channels follow their input register
      if (cmd != `QDC_CMD_RSVD && cmd != `QDC_CMD_RESET)
        for (int i = 0; i < 4; i++)
          if (ld_q[i]) chreg_d[i] = inreg_d[i];
    end
  end

  // channel state, zero at power-up
  always_ff @(posedge REF_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      inreg_q <= '0;
      chreg_q <= '0;
      pd_q    <= '0;
      ld_q    <= 4'h0;
    end
    else
    begin
      inreg_q <= inreg_d;
      chreg_q <= chreg_d;
      pd_q    <= pd_d;
      ld_q    <= ld_d;
    end
  end

  // frame counter and completion pulse
  always_ff @(posedge REF_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      frames_q <= 16'h0;
      done_q   <= 1'b0;
    end
    else
    begin
      done_q <= exec_go;
      if (exec_go)
        frames_q <= frames_q + 16'h1;
    end
  end

  // wishbone slave, one wait state, unmapped reads zero
  always_ff @(posedge REF_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0;
      en_q   <= `QDC_CTRL_RESET;
    end
    else
    begin
      ack_q <= WB_CYC_I && WB_STB_I && !ack_q;
      if (WB_CYC_I && WB_STB_I && !ack_q)
      begin
        rdat_q <= 32'h0;
        unique case (WB_ADR_I)
          `QDC_REG_CTRL:   rdat_q[`QDC_CTRL_EN_BIT] <= en_q;
          `QDC_REG_STATUS: rdat_q <= {19'h0,
                                      state_q != QDC_IDLE,
                                      ld_q, pd_q};
          `QDC_REG_FRAMES: rdat_q <= {16'h0, frames_q};
          `QDC_REG_CHAN_BASE:
            rdat_q <= 32'(chreg_q[0]);
          `QDC_REG_CHAN_BASE + 8'h04:
            rdat_q <= 32'(chreg_q[1]);
          `QDC_REG_CHAN_BASE + 8'h08:
            rdat_q <= 32'(chreg_q[2]);
          `QDC_REG_CHAN_BASE + 8'h0C:
            rdat_q <= 32'(chreg_q[3]);
          default:         rdat_q <= 32'h0;
        endcase
      end
      if (WB_CYC_I && WB_STB_I && WB_WE_I && ack_q && WB_SEL_I[0]
          && WB_ADR_I == `QDC_REG_CTRL)
        en_q <= WB_DAT_I[`QDC_CTRL_EN_BIT];
    end
  end

  // outputs straight from flip-flops
  assign WB_ACK_O     = ack_q;
  assign WB_DAT_O     = rdat_q;
  assign CHAN_CODE_O  = chreg_q;
  assign PD_MODE_O    = pd_q;
  assign LOAD_CTRL_O  = ld_q;
  assign FRAME_DONE_O = done_q;

  // checks
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (SYS_RST_I);

  sequence s_start;
    state_q == QDC_IDLE && sync_fall && en_q;
  endsequence

  sequence s_last_edge;
    exec_go;
  endsequence

  a_frame_start: assert property (s_start |=>
    state_q == QDC_SHIFT && cnt_q == 5'h0 && shift_q == '0)
    else $error("frame did not start on select fall");

  a_exec_24th: assert property (
    (state_q == QDC_SHIFT && cnt_q == LAST_BIT && sclk_fall && !sync_high)
    |=> state_q == QDC_DONE ##0 done_q)
    else $error("no execution on the last edge");

  a_abort_clean: assert property (
    (state_q == QDC_SHIFT && sync_high) |=> state_q == QDC_IDLE
    && $stable(chreg_q) && $stable(pd_q) && $stable(ld_q) && !done_q)
    else $error("aborted frame changed state");

  a_done_deaf: assert property (
    (state_q == QDC_DONE && !sync_high) |=> $stable(chreg_q)
    && $stable(inreg_q) && $stable(cnt_q))
    else $error("edges after last bit were used");

  a_write_update: assert property (
    (s_last_edge and (cmd == `QDC_CMD_WR_UPD && addr == 3'h0))
    |=> chreg_q[0] == $past(code) && inreg_q[0] == $past(code))
    else $error("write and update missed channel a");

  a_reserved_idle: assert property (
    (s_last_edge and (cmd == `QDC_CMD_RSVD)) |=> $stable(chreg_q)
    && $stable(inreg_q) && $stable(pd_q) && $stable(ld_q))
    else $error("reserved command changed state");

  a_reset_full: assert property (
    (s_last_edge and (cmd == `QDC_CMD_RESET && word[0]))
    |=> chreg_q == '0 && pd_q == '0 && ld_q == 4'h0 && inreg_q == '0)
    else $error("full reset left state");

  a_reset_part: assert property (
    (s_last_edge and (cmd == `QDC_CMD_RESET && !word[0]))
    |=> chreg_q == '0 && $stable(ld_q) && $stable(pd_q))
    else $error("partial reset wrong");

  a_power_mode: assert property (
    (s_last_edge and (cmd == `QDC_CMD_POWER && word[0]))
    |=> pd_q[0] == $past(word[5:4]) && ($past(ld_q[0]) || $stable(chreg_q[0])))
    else $error("power mode not taken");

  a_por_zero: assert property (
    $past(SYS_RST_I) |-> chreg_q == '0 && pd_q == '0)
    else $error("channels not zero after reset");

  a_ack_single: assert property (
    ack_q |=> !ack_q)
    else $error("ack longer than one cycle");

endmodule : qdc_top

`default_nettype wire

// *** tb/qdc_host.sv ***
// serial host model driving the command port link
`timescale 1ns/1ns
`default_nettype none

module qdc_host (
  // link pins
  output logic sel_n_o,
  output logic sclk_o,
  output logic sdata_o
);
  // idle: select high, clock parked high
  initial
  begin
    sel_n_o = 1'b1;
    sclk_o  = 1'b1;
    sdata_o = 1'b0;
  end

  // one frame of nb bits msb first, then ex stray falls
  task send(input logic [23:0] w, input int nb, input int ex);
    int i;
    sel_n_o = 1'b1; // raised shortly before the frame
    #80;
    sel_n_o = 1'b0;
    #80;
    for (i = 0; i < nb + ex; i++)
    begin
      sdata_o = (i < 24) ? w[23-i] : ~sdata_o;
      #80 sclk_o = 1'b0;
      #80 sclk_o = 1'b1;
    end
    #80;
    if (nb < 24) // complete frames idle select low
      sel_n_o = 1'b1; // a rise before the 24th fall cuts the frame
    sdata_o = ~sdata_o; // released line shows no stale bit
    #200;
  endtask : send
endmodule : qdc_host
`default_nettype wire

// *** tb/qdc_top_bench.sv ***
// self-checking bench of the quad dac command port
`timescale 1ns/1ns
`default_nettype none

module qdc_top_bench;
  // stimulus and observed signals
  logic        clk  = 1'b0;
  logic        rst  = 1'b1;
  logic        cyc  = 1'b0;
  logic        stb  = 1'b0;
  logic        we   = 1'b0;
  logic [7:0]  adr  = 8'h00;
  logic [3:0]  sel  = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic        ack, done, sel_n, sclk, sdat, en;
  logic [63:0] code;
  logic [7:0]  pd;
  logic [3:0]  ld;
  logic [31:0] seed = 32'h4D;
  int          failures = 0;
  int          n_tests = 0;
  int          frames = 0;
  int          pulses = 0;
  int          in_r[4], ch[4], pm[4], lc;

  // clock and done pulse counter
  always #10 clk = ~clk;
  always @(posedge clk) if (done === 1'b1) pulses <= pulses + 1;

  qdc_top qdc_top_inst (.REF_CLK_I(clk), .SYS_RST_I(rst),
    .FRAME_SEL_N_I(sel_n), .SER_CLK_I(sclk), .SER_DATA_I(sdat),
    .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .CHAN_CODE_O(code), .PD_MODE_O(pd), .LOAD_CTRL_O(ld),
    .FRAME_DONE_O(done));
  qdc_host qdc_host_inst (.sel_n_o(sel_n), .sclk_o(sclk), .sdata_o(sdat));

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task tally_and_finish();
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish

  // classic wishbone single cycle, waits for ack
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d,
          output logic [31:0] r);
    @(posedge clk);
    {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, 4'hF, d};
    do
      @(posedge clk);
    while (ack !== 1'b1);
    r = rdat;
    {cyc, stb} <= 2'b00;
  endtask : wb

  // reference behaviour of one complete frame
  task model(input logic [23:0] w);
    int i, l;
    logic [3:0] m;
    m = (w[18:16] == 3'h7) ? 4'hF : (w[18] ? 4'h0 : 4'h1 << w[17:16]);
    l = lc;
    frames++;
    for (i = 0; i < 4; i++)
    begin
      case (w[21:19])
        3'h0: if (m[i]) in_r[i] = w[15:0];
        3'h1: if (m[i]) ch[i] = in_r[i];
        3'h2: begin if (m[i]) in_r[i] = w[15:0]; ch[i] = in_r[i]; end
        3'h3: if (m[i]) begin in_r[i] = w[15:0]; ch[i] = in_r[i]; end
        3'h4: if (w[i]) pm[i] = w[5:4];
        3'h5: begin ch[i] = 0; if (w[0]) begin in_r[i] = 0; pm[i] = 0;
              lc = 0; end end
        3'h6: lc = w[3:0];
        default: ;
      endcase
      if (w[21:19] != 3'h5 && w[21:19] != 3'h7 && l[i]) ch[i] = in_r[i];
    end
  endtask : model

  // compare channel code, mode, load and done outputs with the reference
  task check_all();
    int i;
    repeat (10) @(posedge clk);
    for (i = 0; i < 4; i++)
    begin
      chk("code", code[16*i +: 16], ch[i]);
      chk("mode", pd[2*i +: 2], pm[i]);
    end
    chk("load", ld, lc);
    chk("done", pulses, frames);
  endtask : check_all

  task frame(input logic [23:0] w, input int nb, input int ex);
    qdc_host_inst.send(w, nb, ex);
    if (nb == 24 && en) model(w);
    check_all();
  endtask : frame

  // watchdog
  initial
  begin
    #1000000;
    failures++;
    tally_and_finish();
  end

  // main sequence
  initial
  begin
    int i;
    logic [23:0] w;
    logic [31:0] q;
    logic [31:0] rnd;
    en = 1'b1;
    for (i = 0; i < 4; i++) {in_r[i], ch[i], pm[i]} = '0;
    lc = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check_all();
    wb(1'b0, 8'h00, 32'h0, q);
    chk("ctrl", q, 32'h1);
    wb(1'b0, 8'h40, 32'h0, q);
    chk("unmapped", q, 32'h0);
    // write and update every address code
    for (i = 0; i < 8; i++)
    begin
      rnd = xs();
      w = rnd[23:0];
      w[21:16] = {3'h3, i[2:0]};
      frame(w, 24, 0);
    end
    // every command and power mode, random payloads
    for (i = 0; i < 20; i++)
    begin
      rnd = xs();
      w = rnd[23:0];
      w[21:19] = i[2:0];
      if (i >= 16) w[21:19] = 3'h4;
      if (i >= 16) w[5:4] = i[1:0];
      frame(w, 24, 0);
    end
    // early abort at boundary, then stray falls
    rnd = xs();
    w = {2'b00, 3'h3, 3'h7, rnd[15:0]};
    frame(w, 12, 0);
    frame(w, 23, 0);
    rnd = xs();
    w[15:0] = rnd[15:0];
    frame(w, 24, 8);
    // port disabled ignores frames
    wb(1'b1, 8'h00, 32'h0, q);
    en = 1'b0;
    rnd = xs();
    frame({2'b00, 3'h3, 3'h7, rnd[15:0]}, 24, 0);
    en = 1'b1;
    wb(1'b1, 8'h00, 32'h1, q);
    wb(1'b0, 8'h04, 32'h0, q);
    chk("status", q[12:0], {1'b0, lc[3:0], pm[3][1:0], pm[2][1:0],
        pm[1][1:0], pm[0][1:0]});
    wb(1'b0, 8'h08, 32'h0, q);
    chk("frames", q[15:0], frames[15:0]);
    wb(1'b0, 8'h10, 32'h0, q);
    chk("chan_a", q[15:0], ch[0]);
    tally_and_finish();
  end
endmodule : qdc_top_bench
`default_nettype wire
